// File: common/sadc_map.svh
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

// rising-edge pulse numbers counted from the start bit
`define SADC_PULSE_START   5'h01
`define SADC_PULSE_CFG     5'h02
`define SADC_PULSE_MSB     5'h04
`define SADC_PULSE_LSB     5'h0B
`define SADC_PULSE_LAST    5'h13
`define SADC_PULSE_MAX     5'h1F

// output pin level while enabled but before the first data bit
`define SADC_IDLE_BIT      1'h0

// comparator settle time per trial, in ns, and synchroniser depth
`define SADC_SETTLE_NS     40
`define SADC_CLK_MHZ       125
`define SADC_SYNC_STAGES   2

`endif

// File: common/sadc_pkg.sv
`default_nettype none
package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_PS_IDLE  = 2'b00,
    SADC_PS_START = 2'b01,
    SADC_PS_ADDR  = 2'b10,
    SADC_PS_DATA  = 2'b11
  } sadc_port_state_t;

  typedef enum logic [1:0] {
    SADC_SAR_IDLE  = 2'b00,
    SADC_SAR_SIGN  = 2'b01,
    SADC_SAR_TRIAL = 2'b10,
    SADC_SAR_DONE  = 2'b11
  } sadc_sar_state_t;

endpackage : sadc_pkg
`default_nettype wire

// File: design/sadc_sar.sv
`timescale 1ns/1ps
`default_nettype none
`include "sadc_map.svh"

module sadc_sar #(
  parameter int RES_W = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // control
  input  wire logic             start,
  input  wire logic             abort,
  // synchronised comparator: positive minus negative at or above dac level
  input  wire logic             cmp_above,
  // analog side
  output logic [RES_W-1:0]      dac_code,
  output logic                  hold_active,
  // result
  output logic [RES_W-1:0]      result,
  output logic                  done
);
  import sadc_pkg::*;

  // settle rounds up, plus the comparator synchroniser latency
  localparam int SETTLE_CYC = (`SADC_SETTLE_NS * `SADC_CLK_MHZ + 999) / 1000;
  localparam int WAIT_CYC   = SETTLE_CYC + `SADC_SYNC_STAGES;
  localparam int WAIT_W     = $clog2(WAIT_CYC + 1);
  localparam int IDX_W      = $clog2(RES_W);

  sadc_sar_state_t   state_reg;
  logic [WAIT_W-1:0] wait_reg;
  logic [IDX_W-1:0]  idx_reg;
  logic              settled;

  assign settled = (wait_reg == '0);

  // successive approximation with a leading sign test against code zero
  always_ff @(posedge clk) begin
    if (srst || abort) begin
      state_reg   <= SADC_SAR_IDLE;
      wait_reg    <= '0;
      idx_reg     <= '0;
      dac_code    <= '0;
      hold_active <= 1'b0;
      result      <= '0;
      done        <= 1'b0;
    end else begin
      unique case (state_reg)
        SADC_SAR_IDLE: begin
          if (start) begin
            state_reg   <= SADC_SAR_SIGN;
            dac_code    <= '0;
            wait_reg    <= WAIT_W'(WAIT_CYC);
            hold_active <= 1'b1;
            done        <= 1'b0;
          end
        end
        SADC_SAR_SIGN: begin
          if (!settled) begin
            wait_reg <= wait_reg - 1'b1;
          end else if (!cmp_above) begin
            result      <= '0;
            state_reg   <= SADC_SAR_DONE;
            hold_active <= 1'b0;
            done        <= 1'b1;
          end else begin
            idx_reg               <= IDX_W'(RES_W - 1);
            dac_code              <= '0;
            dac_code[RES_W-1]     <= 1'b1;
            wait_reg              <= WAIT_W'(WAIT_CYC);
            state_reg             <= SADC_SAR_TRIAL;
          end
        end
        SADC_SAR_TRIAL: begin
          if (!settled) begin
            wait_reg <= wait_reg - 1'b1;
          end else if (idx_reg == '0) begin
            result      <= {dac_code[RES_W-1:1], cmp_above};
            dac_code[0] <= cmp_above;
            state_reg   <= SADC_SAR_DONE;
            hold_active <= 1'b0;
            done        <= 1'b1;
          end else begin
            dac_code[idx_reg]        <= cmp_above;
            dac_code[idx_reg - 1'b1] <= 1'b1;
            idx_reg                  <= idx_reg - 1'b1;
            wait_reg                 <= WAIT_W'(WAIT_CYC);
          end
        end
        SADC_SAR_DONE: begin
          done <= 1'b1;
        end
      endcase
    end
  end

endmodule // sadc_sar

`default_nettype wire

// File: design/sadc_serial_port.sv
// Contract
// - select low enables logic, output undriven until third rising edge
// - first high command bit is start
// - command bit shifted on each rising edge
// - next two bits: mode, then channel/polarity
// - single-ended 10 input a, 11 input b
// - differential 00 a positive, 01 b positive
// - positive below negative gives all zeros
// - result by successive approximation search
// - after config bits convert, drive output
// - ignore command input after addressing
// - MSB-first on falling edges 4 to 11
// - then LSB-first on pulses 12 to 19
// - host raises select after pulse 19
// - output undriven when select rises
// - select is active low, gates activity
`timescale 1ns/1ps
`default_nettype none
`include "sadc_map.svh"

module sadc_serial_port #(
  parameter int RES_W = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // serial pins from the host
  input  wire logic             sel_n_pin,
  input  wire logic             sclk_pin,
  input  wire logic             serial_cmd_in,
  // result pin, two signals of a tri-state pin
  output logic                  result_out,
  output logic                  result_oe_n,
  // analog front end
  input  wire logic             cmp_above_pin,
  output logic                  in_pos_is_b,
  output logic                  in_neg_is_gnd,
  output logic                  hold_active,
  output logic [RES_W-1:0]      dac_code
);
  import sadc_pkg::*;

  localparam int IDX_W = $clog2(RES_W);

  logic [1:0]       sel_sync_reg;
  logic [2:0]       sclk_sync_reg;
  logic [1:0]       cmd_sync_reg;
  logic [1:0]       cmp_sync_reg;
  sadc_port_state_t state_reg;
  logic [4:0]       pulse_cnt_reg;
  logic             single_diff_select;
  logic             conv_start_reg;
  logic [RES_W-1:0] result_word;
  logic             conv_done;
  logic             sel_active;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             cmd_bit;
  logic             cfg_last;

  // picks the result bit launched on a given falling-edge pulse
  function automatic logic result_bit(input logic [RES_W-1:0] word, input logic [4:0] pulse);
    logic [4:0] pos;
    pos = 5'h00;
    if (pulse <= `SADC_PULSE_LSB) begin
      pos = `SADC_PULSE_LSB - pulse;
    end else if (pulse < `SADC_PULSE_LAST) begin
      pos = pulse - `SADC_PULSE_LSB;
    end else begin
      pos = 5'(RES_W - 1);
    end
    return word[pos[IDX_W-1:0]];
  endfunction

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_sync_reg  <= 2'h3;
      sclk_sync_reg <= 3'h0;
      cmd_sync_reg  <= 2'h0;
      cmp_sync_reg  <= 2'h0;
    end else begin
      sel_sync_reg  <= {sel_sync_reg[0], sel_n_pin};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
      cmd_sync_reg  <= {cmd_sync_reg[0], serial_cmd_in};
      cmp_sync_reg  <= {cmp_sync_reg[0], cmp_above_pin};
    end
  end

  assign sel_active = ~sel_sync_reg[1];
  assign sclk_rise  = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall  = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign cmd_bit    = cmd_sync_reg[1];
  assign cfg_last   = (state_reg == SADC_PS_ADDR) && sclk_rise
                      && (pulse_cnt_reg == `SADC_PULSE_CFG);

  // cycle sequencing; select high returns to idle
  always_ff @(posedge clk) begin
    if (srst || !sel_active) begin
      state_reg <= SADC_PS_IDLE;
    end else begin
      unique case (state_reg)
        SADC_PS_IDLE: begin
          state_reg <= SADC_PS_START;
        end
        SADC_PS_START: begin
          if (sclk_rise && cmd_bit) begin
            state_reg <= SADC_PS_ADDR;
          end
        end
        SADC_PS_ADDR: begin
          if (cfg_last) begin
            state_reg <= SADC_PS_DATA;
          end
        end
        SADC_PS_DATA: begin
          state_reg <= SADC_PS_DATA;
        end
      endcase
    end
  end

  // rising-edge pulse count from the start bit, saturating
  always_ff @(posedge clk) begin
    if (srst || !sel_active) begin
      pulse_cnt_reg <= 5'h00;
    end else if (state_reg == SADC_PS_START) begin
      if (sclk_rise && cmd_bit) begin
        pulse_cnt_reg <= `SADC_PULSE_START;
      end
    end else if (sclk_rise && state_reg != SADC_PS_IDLE
                 && pulse_cnt_reg != `SADC_PULSE_MAX) begin
      pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
    end
  end

  // address shift: only active during addressing
  always_ff @(posedge clk) begin
    if (srst || !sel_active) begin
      single_diff_select <= 1'b0;
      in_pos_is_b        <= 1'b0;
      in_neg_is_gnd      <= 1'b1;
      conv_start_reg     <= 1'b0;
    end else begin
      conv_start_reg <= cfg_last;
      if (state_reg == SADC_PS_ADDR && sclk_rise) begin
        if (pulse_cnt_reg == `SADC_PULSE_START) begin
          single_diff_select <= cmd_bit;
        end else begin
          in_pos_is_b   <= cmd_bit;
          in_neg_is_gnd <= single_diff_select;
        end
      end
    end
  end

  // result pin driver
  always_ff @(posedge clk) begin
    if (srst || !sel_active) begin
      result_oe_n <= 1'b1;
      result_out  <= `SADC_IDLE_BIT;
    end else if (cfg_last) begin
      result_oe_n <= 1'b0;
      result_out  <= `SADC_IDLE_BIT;
    end else if (state_reg == SADC_PS_DATA && sclk_fall
                 && pulse_cnt_reg >= `SADC_PULSE_MSB) begin
      // a host that outruns the conversion reads the idle level
      if (conv_done) begin
        result_out <= result_bit(result_word, pulse_cnt_reg);
      end else begin
        result_out <= `SADC_IDLE_BIT;
      end
    end
  end

  sadc_sar #(
    .RES_W (RES_W)
  ) u_sar (
    .clk         (clk),
    .srst        (srst),
    .start       (conv_start_reg),
    .abort       (!sel_active),
    .cmp_above   (cmp_sync_reg[1]),
    .dac_code    (dac_code),
    .hold_active (hold_active),
    .result      (result_word),
    .done        (conv_done)
  );

endmodule // sadc_serial_port

`default_nettype wire

// File: dv/sadc_props.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_props #(
  parameter int RES_W = 8
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             srst,
  // host pins
  input wire logic             sel_n_pin,
  input wire logic             sclk_pin,
  input wire logic             serial_cmd_in,
  input wire logic             result_out,
  input wire logic             result_oe_n,
  // analog side
  input wire logic             cmp_above_pin,
  input wire logic             in_pos_is_b,
  input wire logic             in_neg_is_gnd,
  input wire logic             hold_active,
  input wire logic [RES_W-1:0] dac_code
);
  logic       sclk_q;
  logic [4:0] rise_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // serial clock rises seen at the pin within the current select window
  always_ff @(posedge clk) begin
    sclk_q <= sclk_pin;
    if (srst || sel_n_pin) begin
      rise_cnt <= 5'h00;
    end else if (sclk_pin && !sclk_q && rise_cnt != 5'h1F) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  sequence sel_up;
    $rose(sel_n_pin);
  endsequence
  sequence sign_test;
    (dac_code == '0) [*4];
  endsequence

  idle_undriven_a: assert property (sel_n_pin [*4] |-> result_oe_n)
    else $error("result pin driven while deselected");
  release_on_sel_a: assert property (sel_up |-> ##[1:4] result_oe_n)
    else $error("result pin not released after select rise");
  drive_after_cfg_a: assert property ($fell(result_oe_n) |-> rise_cnt >= 5'h03)
    else $error("result pin driven before three clock pulses");
  no_early_data_a: assert property ($fell(result_oe_n) |-> !result_out && !sel_n_pin)
    else $error("data bit present before fourth pulse");
  out_on_fall_a: assert property ($changed(result_out) |-> !sclk_pin)
    else $error("result bit changed while serial clock high");
  cfg_frozen_a: assert property (!result_oe_n && !$past(result_oe_n) |->
    $stable(in_pos_is_b) && $stable(in_neg_is_gnd))
    else $error("input selection changed after addressing");
  conv_bounded_a: assert property ($rose(hold_active) |-> ##[1:100] !hold_active)
    else $error("conversion did not finish in time");
  sign_first_a: assert property ($rose(hold_active) |-> sign_test)
    else $error("sign test not run at zero code");
endmodule // sadc_props

bind sadc_serial_port sadc_props #(.RES_W(RES_W)) i_props (
  .clk(clk), .srst(srst), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
  .serial_cmd_in(serial_cmd_in), .result_out(result_out), .result_oe_n(result_oe_n),
  .cmp_above_pin(cmp_above_pin), .in_pos_is_b(in_pos_is_b),
  .in_neg_is_gnd(in_neg_is_gnd), .hold_active(hold_active), .dac_code(dac_code));
`default_nettype wire

// File: dv/sadc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_afe_model (
  // levels on the two analog inputs
  input  wire logic [7:0] level_a,
  input  wire logic [7:0] level_b,
  // mux and trial code from the device
  input  wire logic       in_pos_is_b,
  input  wire logic       in_neg_is_gnd,
  input  wire logic [7:0] dac_code,
  // comparator result
  output logic            cmp_above
);
  int pos;
  int neg;
  always_comb begin
    pos = in_pos_is_b ? int'(level_b) : int'(level_a);
    neg = in_neg_is_gnd ? 0 : (in_pos_is_b ? int'(level_a) : int'(level_b));
    cmp_above = (pos - neg) >= int'(dac_code);
  end
endmodule // sadc_afe_model
`default_nettype wire

// File: dv/sadc_serial_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_serial_port_test;
  localparam int HALF = 200;
  logic        clk;
  logic        srst;
  logic        sel_n;
  logic        sclk;
  logic        cmd;
  logic        cmp;
  logic        out;
  logic        oe_n;
  logic        pos_b;
  logic        neg_gnd;
  logic [7:0]  dac;
  logic [7:0]  level_a;
  logic [7:0]  level_b;
  logic [31:0] seed = 32'h000155C8;
  logic [31:0] r;
  int          miscompares = 0;
  int          num_checks = 0;

  sadc_serial_port #(.RES_W(8)) i_dut (
    .clk(clk), .srst(srst), .sel_n_pin(sel_n), .sclk_pin(sclk), .serial_cmd_in(cmd),
    .result_out(out), .result_oe_n(oe_n), .cmp_above_pin(cmp), .in_pos_is_b(pos_b),
    .in_neg_is_gnd(neg_gnd), .hold_active(), .dac_code(dac));
  sadc_afe_model i_afe (
    .level_a(level_a), .level_b(level_b), .in_pos_is_b(pos_b),
    .in_neg_is_gnd(neg_gnd), .dac_code(dac), .cmp_above(cmp));

  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] word(input logic [1:0] cfg, input logic [7:0] a, b);
    int p;
    int n;
    p = cfg[0] ? int'(b) : int'(a);
    n = cfg[1] ? 0 : (cfg[0] ? int'(a) : int'(b));
    return (p < n) ? 8'h00 : 8'(p - n);
  endfunction

  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one host cycle; lead adds an ignored low pulse, stop cuts the cycle short
  task automatic frame(input logic [1:0] cfg, input logic [7:0] a, b, input int lead, stop);
    logic [7:0] w;
    w = word(cfg, a, b);
    level_a = a;
    level_b = b;
    sel_n = 1'b0;
    repeat (HALF) @(negedge clk);
    check_bit("oe_n idle", 1'b1, oe_n);
    for (int p = 1 - lead; p <= stop; p++) begin
      r = rnd();
      cmd = (p == 1) ? 1'b1 : (p == 2) ? cfg[1] : (p == 3) ? cfg[0] : (p > 3) & r[0];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      if (p >= 5) check_bit("result bit", p <= 12 ? w[12-p] : w[p-12], out);
      if (p >= 4) check_bit("oe_n driving", 1'b0, oe_n);
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    if (stop == 19) check_bit("last bit", w[7], out);
    sel_n = 1'b1;
    repeat (8) @(negedge clk);
    check_bit("oe_n released", 1'b1, oe_n);
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    sel_n = 1'b1;
    sclk = 1'b0;
    cmd = 1'b0;
    level_a = 8'h00;
    level_b = 8'h00;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    // start bits clocked while deselected must be ignored
    cmd = 1'b1;
    for (int k = 0; k < 4; k++) begin
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    check_bit("oe_n deselected", 1'b1, oe_n);
    check_bit("out deselected", 1'b0, out);
    cmd = 1'b0;
    repeat (8) @(negedge clk);
    frame(2'b00, 8'h10, 8'h90, 1, 19);
    frame(2'b11, 8'h00, 8'hFF, 0, 6);
    frame(2'b10, 8'hFF, 8'h00, 0, 19);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      frame(2'(i), r[7:0], r[15:8], int'(r[16]), 19);
    end
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule // sadc_serial_port_test
`default_nettype wire
